// ### inc/xacc_mem_if.sv
// Port bundle between the controller and the XRAM array
`timescale 1ns/10ps
`default_nettype none
interface xacc_mem_if #(
    parameter int AW = 11
);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### inc/xacc_pkg.sv
// Constants for the external data move access controller
package xacc_pkg;
    // ========================================================
    // Register map
    localparam logic [7:0]  REG_SYS_CTRL   = 8'hb1;
    localparam logic [7:0]  REG_XRAM_PAGE  = 8'h91;
    localparam logic [7:0]  REG_STATUS     = 8'h92;
    // ========================================================
    // Fields and reset values
    localparam int          SYS_GDIS_BIT   = 0;
    localparam int          SYS_VIS_BIT    = 1;
    localparam logic        GDIS_RST       = 1'b1;
    localparam logic        VIS_RST        = 1'b0;
    localparam logic [7:0]  PAGE_RST       = 8'h00;
    localparam int          ST_BUSY_BIT    = 0;
    localparam int          ST_INT_BIT     = 1;
    localparam int          ST_EA_BIT      = 2;
    // ========================================================
    // Address map of the upper range
    localparam logic [15:0] INT_LOW        = 16'hf700;
    localparam logic [15:0] CAN_BASE       = 16'hf700;
    localparam logic [15:0] CAN_LAST       = 16'hf7ff;
    localparam logic [15:0] XRAM_BASE      = 16'hf800;
    localparam int          XRAM_DEPTH     = 2048;
    localparam int          XRAM_AW        = 11;
    localparam int          CAN_AW         = 8;
    // ========================================================
    // Bus cycle timing
    localparam int          CLK_NS         = 8;
    localparam int          ALE_NS         = 16;
    localparam int          ALE_CYC        = (ALE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          STB_NS         = 40;
    localparam int          STB_CYC        = (STB_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### rtl/xacc_decode.sv
// Upper range address decoder
`timescale 1ns/10ps
`default_nettype none
module xacc_decode (
    input  wire logic [15:0] eff_addr,
    input  wire logic        gdis,
    output logic             hit_can,
    output logic             hit_xram,
    output logic             internal
);
    wire in_range = (eff_addr >= xacc_pkg::INT_LOW);
    wire can_rng  = (eff_addr >= xacc_pkg::CAN_BASE) && (eff_addr <= xacc_pkg::CAN_LAST);
    wire xram_rng = (eff_addr >= xacc_pkg::XRAM_BASE);

    assign internal = in_range && !gdis;
    assign hit_can  = internal && can_rng;
    assign hit_xram = internal && xram_rng;
endmodule // xacc_decode
`default_nettype wire

// ### rtl/xacc_top.sv
// External data move access controller: XRAM, CAN window and external bus
`timescale 1ns/10ps
`default_nettype none
module xacc_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    // CPU move request
    input  wire logic        cpu_req,
    input  wire logic        cpu_we,
    input  wire logic        cpu_use_ptr,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    output logic             cpu_busy,
    output logic             cpu_done,
    output logic [7:0]       cpu_rdata,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // CAN controller window
    output logic             can_sel,
    output logic             can_we,
    output logic [7:0]       can_addr,
    output logic [7:0]       can_wdata,
    input  wire logic [7:0]  can_rdata,
    // External bus pins
    input  wire logic        ext_access_pin,
    input  wire logic [7:0]  p0_in,
    output logic [7:0]       p0_out,
    output logic             p0_oe,
    output logic [7:0]       p2_out,
    output logic             p2_oe,
    output logic             ale,
    output logic             rd_n,
    output logic             wr_n
);
    // ========================================================
    // Elaboration check
    // Filtered port 0 settles four edges into the strobe
    if (xacc_pkg::STB_CYC < 5) begin : g_chk
        $error("xacc_top strobe must outlast the pin filter");
    end

    typedef enum logic [1:0] {XACC_IDLE, XACC_ADDR, XACC_STRB, XACC_DONE} xacc_state_t;

    xacc_state_t state_ff;
    xacc_state_t nxt_state;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic        gdis_ff;
    logic        vis_ff;
    logic [7:0]  page_ff;
    logic [7:0]  reg_rdata_ff;
    logic        we_ff;
    logic        ptr_ff;
    logic [15:0] addr_ff;
    logic [7:0]  wdata_ff;
    logic [7:0]  rdata_ff;
    logic        done_ff;
    logic        last_int_ff;
    logic [8:0]  sync1_ff;
    logic [8:0]  sync2_ff;
    logic [8:0]  sync3_ff;
    logic [8:0]  filt_ff;

    xacc_mem_if #(.AW(xacc_pkg::XRAM_AW)) mem_bus ();

    // ========================================================
    // Pin input filter
    // A bit changes only when the second and third stages agree
    wire [8:0] sync_diff = sync2_ff ^ sync3_ff;
    wire [8:0] nxt_filt  = (~sync_diff & sync3_ff) | (sync_diff & filt_ff);
    wire       ea_lvl    = filt_ff[8];
    wire [7:0] p0_lvl    = filt_ff[7:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= 9'h000;
            sync2_ff <= 9'h000;
            sync3_ff <= 9'h000;
            filt_ff  <= 9'h000;
        end else begin
            sync1_ff <= {ext_access_pin, p0_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff  <= nxt_filt;
        end
    end

    // ========================================================
    // Register file
    wire wr_sys  = reg_wr && (reg_addr == xacc_pkg::REG_SYS_CTRL);
    wire wr_page = reg_wr && (reg_addr == xacc_pkg::REG_XRAM_PAGE);
    // the disable bit can only be cleared
    wire nxt_gdis = wr_sys ? (gdis_ff & reg_wdata[xacc_pkg::SYS_GDIS_BIT]) : gdis_ff;
    wire nxt_vis  = wr_sys ? reg_wdata[xacc_pkg::SYS_VIS_BIT] : vis_ff;

    wire [7:0] sys_view  = {6'h00, vis_ff, gdis_ff};
    wire [7:0] stat_view = {5'h00, ea_lvl, last_int_ff, cpu_busy};
    wire [7:0] rd_mux    = (reg_addr == xacc_pkg::REG_SYS_CTRL)  ? sys_view  :
                           (reg_addr == xacc_pkg::REG_XRAM_PAGE) ? page_ff   :
                           (reg_addr == xacc_pkg::REG_STATUS)    ? stat_view : 8'h00;
    wire [7:0] nxt_reg_rdata = reg_rd ? rd_mux : 8'h00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gdis_ff      <= xacc_pkg::GDIS_RST;
            vis_ff       <= xacc_pkg::VIS_RST;
            page_ff      <= xacc_pkg::PAGE_RST;
            reg_rdata_ff <= 8'h00;
        end else begin
            gdis_ff      <= nxt_gdis;
            vis_ff       <= nxt_vis;
            page_ff      <= wr_page ? reg_wdata : page_ff;
            reg_rdata_ff <= nxt_reg_rdata;
        end
    end

    assign reg_rdata = reg_rdata_ff;

    // ========================================================
    // Address decode
    // page register gives the high byte of non-pointer moves
    wire [15:0] eff_addr = ptr_ff ? addr_ff : {page_ff, addr_ff[7:0]};
    wire        hit_can;
    wire        hit_xram;
    wire        internal;

    xacc_decode u_decode (
        .eff_addr (eff_addr),
        .gdis     (gdis_ff),
        .hit_can  (hit_can),
        .hit_xram (hit_xram),
        .internal (internal)
    );

    // ========================================================
    // Sequencer
    wire accept    = (state_ff == XACC_IDLE) && cpu_req;
    wire ale_last  = (cnt_ff == 4'(xacc_pkg::ALE_CYC - 1));
    wire stb_last  = (cnt_ff == 4'(xacc_pkg::STB_CYC - 1));
    wire stb_first = (state_ff == XACC_STRB) && (cnt_ff == 4'h0);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            XACC_IDLE: begin
                nxt_cnt = 4'h0;
                if (cpu_req) begin
                    nxt_state = XACC_ADDR;
                end
            end
            XACC_ADDR: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (ale_last) begin
                    nxt_state = XACC_STRB;
                    nxt_cnt   = 4'h0;
                end
            end
            XACC_STRB: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (stb_last) begin
                    nxt_state = XACC_DONE;
                    nxt_cnt   = 4'h0;
                end
            end
            XACC_DONE: begin
                nxt_state = XACC_IDLE;
                nxt_cnt   = 4'h0;
            end
        endcase
    end

    // Internal read data settle one cycle after the strobe starts
    wire [7:0] int_rdata = hit_xram ? mem_bus.rdata : can_rdata;
    wire       capture   = (state_ff == XACC_STRB) && stb_last && !we_ff;
    wire [7:0] nxt_rdata = capture ? (internal ? int_rdata : p0_lvl) : rdata_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff    <= XACC_IDLE;
            cnt_ff      <= 4'h0;
            we_ff       <= 1'b0;
            ptr_ff      <= 1'b0;
            addr_ff     <= 16'h0000;
            wdata_ff    <= 8'h00;
            rdata_ff    <= 8'h00;
            done_ff     <= 1'b0;
            last_int_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            we_ff       <= accept ? cpu_we : we_ff;
            ptr_ff      <= accept ? cpu_use_ptr : ptr_ff;
            addr_ff     <= accept ? cpu_addr : addr_ff;
            wdata_ff    <= accept ? cpu_wdata : wdata_ff;
            rdata_ff    <= nxt_rdata;
            done_ff     <= (state_ff == XACC_STRB) && stb_last;
            last_int_ff <= (state_ff == XACC_DONE) ? internal : last_int_ff;
        end
    end

    assign cpu_busy  = (state_ff != XACC_IDLE);
    assign cpu_done  = done_ff;
    assign cpu_rdata = rdata_ff;

    // ========================================================
    // Internal targets
    // XRAM only via moves
    assign mem_bus.en    = stb_first && hit_xram;
    assign mem_bus.we    = we_ff;
    assign mem_bus.addr  = eff_addr[xacc_pkg::XRAM_AW-1:0];
    assign mem_bus.wdata = wdata_ff;

    xacc_xram_mem #(
        .DEPTH (xacc_pkg::XRAM_DEPTH),
        .AW    (xacc_pkg::XRAM_AW)
    ) u_xram (
        .clk  (clk),
        .port (mem_bus)
    );

    assign can_sel   = stb_first && hit_can;
    assign can_we    = we_ff;
    assign can_addr  = eff_addr[xacc_pkg::CAN_AW-1:0];
    assign can_wdata = wdata_ff;

    // ========================================================
    // Pin behaviour
    // bits and access pin pick port roles
    // visibility only matters for internal accesses
    wire cyc_on   = (state_ff == XACC_ADDR) || (state_ff == XACC_STRB);
    wire p0_bus   = !internal || vis_ff || !ea_lvl;
    // port 2 carries the high byte of pointer moves while port 0 is on the bus
    wire p2_bus   = ptr_ff && p0_bus;
    // strobes quiet for hidden internal accesses
    wire stb_en   = !internal || vis_ff;
    wire p0_data  = we_ff || internal;

    assign ale    = (state_ff == XACC_ADDR) && p0_bus;
    assign p0_oe  = cyc_on && p0_bus && ((state_ff == XACC_ADDR) || p0_data);
    assign p0_out = !p0_oe ? 8'h00 : (state_ff == XACC_ADDR) ? addr_ff[7:0] :
                    we_ff ? wdata_ff : int_rdata;
    assign p2_oe  = cyc_on && p2_bus;
    assign p2_out = p2_oe ? addr_ff[15:8] : 8'h00;
    assign rd_n   = !((state_ff == XACC_STRB) && stb_en && !we_ff);
    assign wr_n   = !((state_ff == XACC_STRB) && stb_en && we_ff);

    // ========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_hidden_quiet;
        (state_ff == XACC_STRB) && internal && !vis_ff |-> rd_n && wr_n;
    endproperty
    a_hidden_quiet: assert property (p_hidden_quiet) else $error("strobe during hidden access");

    property p_visible_drive;
        (state_ff == XACC_STRB) && internal && vis_ff && we_ff |-> !wr_n && p0_oe && (p2_oe == ptr_ff);
    endproperty
    a_visible_drive: assert property (p_visible_drive) else $error("visible write not on pins");

    property p_vis_no_effect;
        (state_ff == XACC_STRB) && !internal |-> (rd_n == we_ff) && (wr_n == !we_ff) && p0_bus;
    endproperty
    a_vis_no_effect: assert property (p_vis_no_effect) else $error("external cycle altered");

    property p_gdis_outside;
        gdis_ff |-> !internal && !mem_bus.en && !can_sel;
    endproperty
    a_gdis_outside: assert property (p_gdis_outside) else $error("internal access while disabled");

    property p_gdis_sticky;
        !gdis_ff |=> !gdis_ff;
    endproperty
    a_gdis_sticky: assert property (p_gdis_sticky) else $error("disable bit set again");

    property p_ptr_range;
        accept && cpu_use_ptr && (cpu_addr < xacc_pkg::INT_LOW) |=> !internal [*3];
    endproperty
    a_ptr_range: assert property (p_ptr_range) else $error("low pointer taken internal");

    property p_page_addr;
        mem_bus.en && !ptr_ff |-> (mem_bus.addr == {page_ff[2:0], addr_ff[7:0]});
    endproperty
    a_page_addr: assert property (p_page_addr) else $error("page byte not used");

    property p_ea_io;
        cyc_on && internal && !vis_ff && ea_lvl |-> !p0_oe && !p2_oe && !ale;
    endproperty
    a_ea_io: assert property (p_ea_io) else $error("ports left on bus");

    property p_low_strobe;
        accept && cpu_use_ptr && (cpu_addr < xacc_pkg::INT_LOW) && cpu_we |=> ##2 !wr_n [*5];
    endproperty
    a_low_strobe: assert property (p_low_strobe) else $error("external write not strobed");

    property p_disjoint;
        (mem_bus.en || can_sel) |-> (mem_bus.en != can_sel) && (can_sel == (eff_addr <= xacc_pkg::CAN_LAST));
    endproperty
    a_disjoint: assert property (p_disjoint) else $error("overlapping targets");

    property p_xram_top;
        mem_bus.en |-> (state_ff == XACC_STRB) && (eff_addr >= xacc_pkg::XRAM_BASE);
    endproperty
    a_xram_top: assert property (p_xram_top) else $error("array reached outside a move");

    property p_can_window;
        can_sel |-> (eff_addr >= xacc_pkg::CAN_BASE) && (eff_addr <= xacc_pkg::CAN_LAST) && (can_addr == eff_addr[7:0]);
    endproperty
    a_can_window: assert property (p_can_window) else $error("window access outside its range");

    property p_done_time;
        accept |-> ##8 cpu_done;
    endproperty
    a_done_time: assert property (p_done_time) else $error("move not completed in time");

    c_int_hidden: cover property (cpu_done && internal && !vis_ff);
    c_xram_wr:    cover property (mem_bus.en && mem_bus.we && vis_ff);
    c_can_rd:     cover property (can_sel && !can_we);
    c_ext_rd:     cover property (!rd_n && !internal ##1 cpu_busy);
endmodule // xacc_top
`default_nettype wire

// ### rtl/xacc_xram_mem.sv
// On-chip XRAM array with registered read data
`timescale 1ns/10ps
`default_nettype none
module xacc_xram_mem #(
    parameter int DEPTH = 2048,
    parameter int AW    = 11
) (
    input  wire logic   clk,
    xacc_mem_if.mem     port
);
    // ========================================================
    // Elaboration check
    if (DEPTH != (1 << AW)) begin : g_chk
        $error("xacc_xram_mem depth must be two to the address width");
    end

    logic [7:0] mem_ff [DEPTH];
    logic [7:0] rdata_ff;

    // ========================================================
    // Array, no reset on storage
    always_ff @(posedge clk) begin
        if (port.en && port.we) begin
            mem_ff[port.addr] <= port.wdata;
        end
        if (port.en && !port.we) begin
            rdata_ff <= mem_ff[port.addr];
        end
    end

    assign port.rdata = rdata_ff;
endmodule // xacc_xram_mem
`default_nettype wire

// ### tb/xacc_far_side.sv
// Far side model: external memory on the port bus and the CAN window
`timescale 1ns/10ps
`default_nettype none
module xacc_far_side (
    input  wire logic       clk,
    input  wire logic       can_sel,
    input  wire logic       can_we,
    input  wire logic [7:0] can_addr,
    input  wire logic [7:0] can_wdata,
    output logic [7:0]      can_rdata,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] p0_out,
    input  wire logic       p0_oe,
    input  wire logic [7:0] p2_out,
    input  wire logic       p2_oe,
    output logic [7:0]      p0_in
);
    // ========================================
    // Storage
    logic [7:0]  ext_m [65536];
    logic [7:0]  can_m [256];
    logic [15:0] lat_ff;
    logic [7:0]  csel_ff;
    logic [7:0]  last_ff = 8'h5a;
    // ========================================
    // Port 0 wire level
    // multiplexed bus read
    // Released bus toggles so a stale value never looks valid
    assign p0_in     = p0_oe ? p0_out : (!rd_n ? ext_m[lat_ff] : ~last_ff);
    assign can_rdata = can_m[csel_ff];
    always @(posedge clk) begin
        last_ff <= p0_in;
        if (ale) begin
            lat_ff <= {p2_oe ? p2_out : 8'h00, p0_out};
        end
        if (!wr_n && p0_oe) begin
            ext_m[lat_ff] <= p0_out;
        end
        if (can_sel) begin
            csel_ff <= can_addr;
            if (can_we) begin
                can_m[can_addr] <= can_wdata;
            end
        end
    end
endmodule // xacc_far_side
`default_nettype wire

// ### tb/xacc_top_test.sv
// Self-checking bench for the external data move access controller
`timescale 1ns/10ps
`default_nettype none
module xacc_top_test;
    // ========================================
    // Signals and model state
    localparam logic [7:0] SYS = xacc_pkg::REG_SYS_CTRL;
    localparam logic [7:0] PG  = xacc_pkg::REG_XRAM_PAGE;
    localparam logic [7:0] ST  = xacc_pkg::REG_STATUS;
    logic        clk, rstn, cpu_req, cpu_we, cpu_use_ptr, cpu_busy, cpu_done, reg_wr, reg_rd;
    logic        can_sel, can_we, ext_access_pin, p0_oe, p2_oe, ale, rd_n, wr_n;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata, reg_addr, reg_wdata, reg_rdata, can_addr, can_wdata, can_rdata;
    logic [7:0]  p0_in, p0_out, p2_out, page;
    logic [7:0]  ext_e [65536];
    logic [7:0]  xr_e [2048];
    logic [7:0]  can_e [256];
    logic [15:0] addrs [6];
    logic        gdis, vis, ea, last_int;
    logic [31:0] seed;
    int          errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    xacc_top dut (
        .clk, .rstn, .cpu_req, .cpu_we, .cpu_use_ptr, .cpu_addr, .cpu_wdata, .cpu_busy, .cpu_done,
        .cpu_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .can_sel, .can_we, .can_addr,
        .can_wdata, .can_rdata, .ext_access_pin, .p0_in, .p0_out, .p0_oe, .p2_out, .p2_oe, .ale, .rd_n, .wr_n
    );
    xacc_far_side far (
        .clk, .can_sel, .can_we, .can_addr, .can_wdata, .can_rdata, .ale, .rd_n, .wr_n, .p0_out, .p0_oe,
        .p2_out, .p2_oe, .p0_in
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard, far above the fewer than two thousand cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            test_done();
        end
    end
    // ========================================
    // Helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic fail(input string what);
        errors++;
        $display("MISMATCH %0t %s", $time, what);
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) fail("register read");
    endtask
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) fail("move read data");
    endtask
    task automatic chk_pins(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) fail("pin activity during move");
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ========================================
    // Register port
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == SYS) begin
            gdis = gdis & d[xacc_pkg::SYS_GDIS_BIT];
            vis  = d[xacc_pkg::SYS_VIS_BIT];
        end
        if (a == PG) page = d;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk_reg(reg_rdata, exp);
    endtask
    task automatic reset_dut();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        gdis = xacc_pkg::GDIS_RST;
        vis  = xacc_pkg::VIS_RST;
        page = xacc_pkg::PAGE_RST;
        repeat (8) @(posedge clk);
    endtask
    // ========================================
    // One move with pin observation
    task automatic mv(input logic we, input logic ptr, input logic [15:0] a, input logic [7:0] d);
        logic [15:0] eff, ek;
        logic        ie, pb, sb;
        logic [7:0]  rdv, exp;
        int          n, sc, al, p2;
        eff = ptr ? a : {page, a[7:0]};
        ie  = (eff >= xacc_pkg::INT_LOW) && !gdis;
        ek  = ptr ? eff : {8'h00, eff[7:0]};
        pb  = !ie || vis || !ea;
        sb  = !ie || vis;
        n = 0; sc = 0; al = 0; p2 = 0;
        @(posedge clk);
        cpu_req     <= 1'b1;
        cpu_we      <= we;
        cpu_use_ptr <= ptr;
        cpu_addr    <= a;
        cpu_wdata   <= d;
        @(posedge clk);
        cpu_req <= 1'b0;
        while (n < 20) begin
            @(negedge clk);
            n++;
            if (cpu_done === 1'b1) break;
            al += int'(ale === 1'b1);
            p2 += int'(p2_oe === 1'b1);
            sc += int'(rd_n === 1'b0 || wr_n === 1'b0);
            // Stray request while busy must be dropped
            @(posedge clk);
            if (n == 3) cpu_req <= 1'b1;
            if (n == 4) cpu_req <= 1'b0;
        end
        rdv = cpu_rdata;
        @(negedge clk);
        chk_pins({al[3:0], 2'b00, cpu_busy, p2 > 0, sc[3:0], n[3:0]},
                 {pb ? 4'(xacc_pkg::ALE_CYC) : 4'h0, 3'b000, ptr && pb,
                  sb ? 4'(xacc_pkg::STB_CYC) : 4'h0, 4'(xacc_pkg::ALE_CYC + xacc_pkg::STB_CYC + 1)});
        last_int = ie;
        if (we) begin
            if (sb) ext_e[ek] = d;
            if (ie && eff <= xacc_pkg::CAN_LAST) can_e[eff[7:0]] = d;
            if (ie && eff > xacc_pkg::CAN_LAST) xr_e[eff[10:0]] = d;
        end else begin
            exp = !ie ? ext_e[ek] : (eff <= xacc_pkg::CAN_LAST ? can_e[eff[7:0]] : xr_e[eff[10:0]]);
            chk_data(rdv, exp);
        end
    endtask
    task automatic sweep();
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            ext_access_pin <= e[0];
            ea = e[0];
            repeat (8) @(posedge clk);
            for (int i = 0; i < 6; i++) begin
                mv(1'b1, 1'b1, addrs[i], rnd());
                mv(1'b0, 1'b1, addrs[i], 8'h00);
                reg_write(PG, addrs[i][15:8]);
                mv(1'b1, 1'b0, addrs[i], rnd());
                mv(1'b0, 1'b0, addrs[i], 8'h00);
                reg_read(ST, {5'h00, ea, last_int, 1'b0});
            end
        end
    endtask
    task automatic readall();
        for (int i = 0; i < 6; i++) begin
            mv(1'b0, 1'b1, addrs[i], 8'h00);
        end
    endtask
    // ========================================
    // Main sequence
    initial begin
        {rstn, cpu_req, cpu_we, cpu_use_ptr, reg_wr, reg_rd, ext_access_pin} = '0;
        cpu_addr  = 16'h0000;
        {cpu_wdata, reg_addr, reg_wdata} = '0;
        seed  = 32'h00000009;
        ea    = 1'b0;
        addrs = '{16'h0000, 16'hf6ff, 16'hf700, 16'hf7ff, 16'hf800, 16'hffff};
        reset_dut();
        reg_read(SYS, 8'h01);
        reg_read(PG, 8'h00);
        reg_write(ST, 8'hff);
        reg_read(ST, 8'h00);
        reg_write(8'h40, 8'hff);
        reg_read(8'h40, 8'h00);
        sweep();
        reg_write(SYS, 8'h00);
        reg_write(SYS, 8'h01);
        reg_read(SYS, 8'h00);
        for (int v = 0; v < 2; v++) begin
            reg_write(SYS, {6'h00, v[0], 1'b0});
            reg_read(SYS, {6'h00, v[0], 1'b0});
            sweep();
        end
        readall();
        reset_dut();
        reg_read(SYS, 8'h01);
        readall();
        test_done();
    end
endmodule // xacc_top_test
`default_nettype wire
